// [sdram_pin_regs.svh]
// timing and field constants of the sdram pin command interface
// assumes: included by its bare name from both ends and the testbench
`ifndef SDRAM_PIN_REGS_SVH
`define SDRAM_PIN_REGS_SVH
`define CAS_LATENCY        3
`define MASK_READ_LATENCY  2
`define BURST_LEN          4
`define AUTO_CLOSE_BIT     10
`define OFS_CMD            12'h000
`define OFS_ADDR           12'h004
`define OFS_WDATA          12'h008
`define OFS_RDATA          12'h00C
`define OFS_STATUS         12'h010
`define OFS_CTRL           12'h014
`define CMD_OP_LSB         0
`define CMD_BANK_LSB       4
`define CMD_MASK_LSB       8
`define CMD_AUTO_LSB       12
`define CTRL_CKE_LSB       0
`define CTRL_CKE_RST       1'b1
`endif

// [sdram_pin_pkg.sv]
// types shared by the memory end and the testbench of the sdram pin interface
// assumes: nothing beyond the header of constants
`default_nettype none
package sdram_pin_pkg;
  typedef enum logic [3:0] {
    cmd_nop       = 4'h7,
    cmd_activate  = 4'h3,
    cmd_read      = 4'h5,
    cmd_write     = 4'h4,
    cmd_precharge = 4'h2,
    cmd_refresh   = 4'h1,
    cmd_load_mode = 4'h0,
    cmd_burst_stop = 4'h6
  } cmd_t;

  typedef enum logic [2:0] {
    pwr_run         = 3'h0,
    pwr_idle_down   = 3'h1,
    pwr_active_down = 3'h2,
    pwr_suspend     = 3'h3,
    pwr_self_ref    = 3'h4,
    pwr_deep_down   = 3'h5
  } pwr_t;
endpackage
`default_nettype wire

// [sdram_pin_if.sv]
// pin level carrier between controller and memory device
// assumes: one clock aclk; the testbench resolves the dq wire from enables
`timescale 1ns/1ps
`default_nettype none
interface sdram_pin_if #(
  parameter int DQ_W = 32,
  parameter int AD_W = 13
) (
  input wire logic aclk
);
  localparam int NB = DQ_W / 8;
  logic            cke;
  logic            cs_n;
  logic            ras_n;
  logic            cas_n;
  logic            we_n;
  logic [1:0]      bank;
  logic [AD_W-1:0] addr;
  logic [NB-1:0]   byte_mask;
  logic [DQ_W-1:0] dq_ctl_o;
  logic            dq_ctl_oe_n;
  logic [DQ_W-1:0] dq_mem_o;
  logic [NB-1:0]   dq_mem_oe_n;
  logic [DQ_W-1:0] dq_i;

  modport ctl (
    input  aclk, dq_i,
    output cke, cs_n, ras_n, cas_n, we_n, bank, addr, byte_mask,
    output dq_ctl_o, dq_ctl_oe_n
  );
  modport mem (
    input  aclk, cke, cs_n, ras_n, cas_n, we_n, bank, addr, byte_mask, dq_i,
    output dq_mem_o, dq_mem_oe_n
  );
endinterface
`default_nettype wire

// [sdram_bank_state.sv]
// open/closed state and open row of each bank of the memory end
// assumes: driven by the decoded commands of sdram_mem
`timescale 1ns/1ps
`default_nettype none
module sdram_bank_state #(
  parameter int AD_W = 13
) (
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire logic            open_en,
  input  wire logic            close_en,
  input  wire logic            close_all,
  input  wire logic [1:0]      bank,
  input  wire logic [AD_W-1:0] row,
  input  wire logic [1:0]      rd_bank,
  output logic [AD_W-1:0]      rd_row,
  output logic                 any_open
);
  logic [3:0]      open_reg;
  logic [AD_W-1:0] row_reg [4];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      open_reg <= 4'h0;
    end else if (close_en && close_all) begin
      open_reg <= 4'h0;
    end else if (close_en) begin
      open_reg[bank] <= 1'b0;
    end else if (open_en) begin
      open_reg[bank] <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (open_en) begin
      row_reg[bank] <= row;
    end
  end

  assign rd_row   = row_reg[rd_bank];
  assign any_open = |open_reg;
endmodule
`default_nettype wire

// [sdram_mem.sv]
// memory device end: samples the pins, decodes commands, runs bursts
// assumes: controller honours command spacing; small array in flip-flops
`timescale 1ns/1ps
`default_nettype none
`include "sdram_pin_regs.svh"
module sdram_mem #(
  parameter int DQ_W   = 32,
  parameter int AD_W   = 13,
  parameter int COL_W  = 4
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  sdram_pin_if.mem  pins,
  output var sdram_pin_pkg::pwr_t pwr_state,
  output logic [AD_W-1:0]     mode_word
);
  localparam int NB = DQ_W / 8;
  localparam int LAT = `CAS_LATENCY;
  localparam int MLAT = `MASK_READ_LATENCY;

  sdram_pin_pkg::pwr_t pwr_reg;
  sdram_pin_pkg::cmd_t cmd;
  logic                cke_prev_reg;
  logic                rd_burst_reg;
  logic                wr_burst_reg;
  logic [2:0]          beat_reg;
  logic [1:0]          burst_bank_reg;
  logic [COL_W-1:0]    col_reg;
  logic                auto_close_reg;
  logic [AD_W-1:0]     mode_reg;
  logic [DQ_W-1:0]     array_reg [4][1<<COL_W];
  logic [LAT-1:0]      rd_pipe_reg;
  logic [DQ_W-1:0]     rd_data_pipe_reg [LAT];
  logic [NB-1:0]       mask_pipe_reg [MLAT];
  logic                clk_on;
  logic                asleep;
  logic                burst_end;
  logic                close_en;
  logic                close_all;
  logic                open_cmd;
  logic [AD_W-1:0]     open_row;
  logic                any_open;

  // sleeping states stop every receiver but clock enable
  assign asleep = (pwr_reg == sdram_pin_pkg::pwr_idle_down) ||
                  (pwr_reg == sdram_pin_pkg::pwr_active_down) ||
                  (pwr_reg == sdram_pin_pkg::pwr_self_ref) ||
                  (pwr_reg == sdram_pin_pkg::pwr_deep_down);
  assign clk_on = pins.cke && cke_prev_reg && !asleep;

  // **********************************************************
  // command decode
  // **********************************************************
  always_comb begin
    cmd = sdram_pin_pkg::cmd_nop;
    if (clk_on && !pins.cs_n) begin
      cmd = sdram_pin_pkg::cmd_t'({1'b0, pins.ras_n, pins.cas_n,
                                   pins.we_n});
    end
  end

  assign close_en  = cmd == sdram_pin_pkg::cmd_precharge;
  assign close_all = pins.addr[`AUTO_CLOSE_BIT];
  assign open_cmd  = cmd == sdram_pin_pkg::cmd_activate;

  // activate and precharge name their bank; auto-close uses the burst's
  sdram_bank_state #(
    .AD_W (AD_W)
  ) sdram_bank_state_inst (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .open_en   (open_cmd),
    .close_en  (close_en || (burst_end && auto_close_reg)),
    .close_all (close_en && close_all),
    .bank      ((close_en || open_cmd) ? pins.bank : burst_bank_reg),
    .row       (pins.addr),
    .rd_bank   (burst_bank_reg),
    .rd_row    (open_row),
    .any_open  (any_open)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= {AD_W{1'b0}};
    end else if (cmd == sdram_pin_pkg::cmd_load_mode) begin
      mode_reg <= pins.addr;
    end
  end

  // **********************************************************
  // clock enable and power states
  // **********************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cke_prev_reg <= 1'b1;
    end else begin
      cke_prev_reg <= pins.cke;
    end
  end

  // wake on clock enable alone while asleep, modelling its async sense
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr_reg <= sdram_pin_pkg::pwr_run;
    end else if (asleep || pwr_reg == sdram_pin_pkg::pwr_suspend) begin
      if (pins.cke) begin
        pwr_reg <= sdram_pin_pkg::pwr_run;
      end
    end else if (!pins.cke) begin
      if (rd_burst_reg || wr_burst_reg) begin
        pwr_reg <= sdram_pin_pkg::pwr_suspend;
      end else if (any_open) begin
        pwr_reg <= sdram_pin_pkg::pwr_active_down;
      end else if (cmd == sdram_pin_pkg::cmd_refresh) begin
        pwr_reg <= sdram_pin_pkg::pwr_self_ref;
      end else if (cmd == sdram_pin_pkg::cmd_burst_stop) begin
        pwr_reg <= sdram_pin_pkg::pwr_deep_down;
      end else begin
        pwr_reg <= sdram_pin_pkg::pwr_idle_down;
      end
    end
  end

  // **********************************************************
  // burst engine
  // **********************************************************
  assign burst_end = clk_on && (rd_burst_reg || wr_burst_reg) &&
                     (beat_reg == 3'(`BURST_LEN - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_burst_reg   <= 1'b0;
      wr_burst_reg   <= 1'b0;
      beat_reg       <= 3'h0;
      col_reg        <= {COL_W{1'b0}};
      burst_bank_reg <= 2'h0;
      auto_close_reg <= 1'b0;
    end else if (cmd == sdram_pin_pkg::cmd_read ||
                 cmd == sdram_pin_pkg::cmd_write) begin
      rd_burst_reg   <= cmd == sdram_pin_pkg::cmd_read;
      wr_burst_reg   <= cmd == sdram_pin_pkg::cmd_write;
      beat_reg       <= 3'h1;
      col_reg        <= pins.addr[COL_W-1:0] + 1'b1;
      burst_bank_reg <= pins.bank;
      auto_close_reg <= pins.addr[`AUTO_CLOSE_BIT];
    end else if (cmd == sdram_pin_pkg::cmd_burst_stop || burst_end) begin
      rd_burst_reg <= 1'b0;
      wr_burst_reg <= 1'b0;
      beat_reg     <= 3'h0;
    end else if (clk_on && (rd_burst_reg || wr_burst_reg)) begin
      beat_reg <= beat_reg + 3'h1;
      col_reg  <= col_reg + 1'b1;
    end
  end

  // write beats: first at the command, following from the counter
  logic             wr_beat;
  logic [1:0]       wr_bank;
  logic [COL_W-1:0] wr_col;
  assign wr_beat = (cmd == sdram_pin_pkg::cmd_write) ||
                   (clk_on && wr_burst_reg &&
                    cmd != sdram_pin_pkg::cmd_burst_stop);
  assign wr_bank = (cmd == sdram_pin_pkg::cmd_write) ? pins.bank
                                                     : burst_bank_reg;
  assign wr_col  = (cmd == sdram_pin_pkg::cmd_write) ?
                   pins.addr[COL_W-1:0] : col_reg;

  always_ff @(posedge aclk) begin
    for (int b = 0; b < NB; b++) begin
      if (wr_beat && !pins.byte_mask[b]) begin
        array_reg[wr_bank][wr_col][8*b +: 8] <= pins.dq_i[8*b +: 8];
      end
    end
  end

  // **********************************************************
  // read pipeline and output drivers
  // **********************************************************
  logic             rd_beat;
  logic [1:0]       rd_bank;
  logic [COL_W-1:0] rd_col;
  assign rd_beat = (cmd == sdram_pin_pkg::cmd_read) ||
                   (clk_on && rd_burst_reg &&
                    cmd != sdram_pin_pkg::cmd_burst_stop);
  assign rd_bank = (cmd == sdram_pin_pkg::cmd_read) ? pins.bank
                                                    : burst_bank_reg;
  assign rd_col  = (cmd == sdram_pin_pkg::cmd_read) ?
                   pins.addr[COL_W-1:0] : col_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_pipe_reg <= {LAT{1'b0}};
      for (int i = 0; i < MLAT; i++) begin
        mask_pipe_reg[i] <= {NB{1'b1}};
      end
    end else if (!asleep) begin
      rd_pipe_reg      <= {rd_pipe_reg[LAT-2:0], rd_beat};
      mask_pipe_reg[0] <= pins.byte_mask;
      for (int i = 1; i < MLAT; i++) begin
        mask_pipe_reg[i] <= mask_pipe_reg[i-1];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!asleep) begin
      rd_data_pipe_reg[0] <= array_reg[rd_bank][rd_col];
      for (int i = 1; i < LAT; i++) begin
        rd_data_pipe_reg[i] <= rd_data_pipe_reg[i-1];
      end
    end
  end

  assign pins.dq_mem_o = rd_data_pipe_reg[LAT-1];
  always_comb begin
    for (int b = 0; b < NB; b++) begin
      pins.dq_mem_oe_n[b] = !(rd_pipe_reg[LAT-1] &&
                              !mask_pipe_reg[MLAT-1][b]);
    end
  end

  assign pwr_state = pwr_reg;
  assign mode_word = mode_reg;
  logic unused_row;
  assign unused_row = ^open_row;
endmodule
`default_nettype wire

// [sdram_ctl.sv]
// controller end: axi4-lite registers issue one pin command each
// assumes: software respects memory timing between commands
`timescale 1ns/1ps
`default_nettype none
`include "sdram_pin_regs.svh"
module sdram_ctl #(
  parameter int DQ_W = 32,
  parameter int AD_W = 13
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  sdram_pin_if.ctl         pins,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  localparam int NB = DQ_W / 8;
  logic            aw_reg, w_reg;
  logic [11:0]     awaddr_reg;
  logic [31:0]     wdata_reg;
  logic [AD_W-1:0] addr_reg;
  logic [DQ_W-1:0] wd_reg, rd_reg;
  logic            cke_reg, issue;
  logic [DQ_W-1:0] dq_s1_reg, dq_s2_reg;
  logic [`CAS_LATENCY+2:0] cap_reg;
  logic            issue_wr;
  logic            issue_rd;
  logic [2:0]      wr_left_reg;

  assign s_axi_awready = !aw_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_reg && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_reg       <= 1'b0;
      w_reg        <= 1'b0;
      s_axi_bvalid <= 1'b0;
      awaddr_reg   <= 12'h000;
      wdata_reg    <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_reg     <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_reg     <= 1'b1;
        wdata_reg <= s_axi_wdata;
      end
      if (aw_reg && w_reg) begin
        aw_reg       <= 1'b0;
        w_reg        <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_bresp = 2'h0;
  assign issue = aw_reg && w_reg && awaddr_reg == `OFS_CMD;
  assign issue_wr = issue && wdata_reg[`CMD_OP_LSB +: 3] == 3'h4;
  assign issue_rd = issue && wdata_reg[`CMD_OP_LSB +: 3] == 3'h5;

  // keep the data lanes driven for every beat of a write burst
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_left_reg <= 3'h0;
    end else if (issue_wr) begin
      wr_left_reg <= 3'(`BURST_LEN - 1);
    end else if (wr_left_reg != 3'h0) begin
      wr_left_reg <= wr_left_reg - 3'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_reg <= {AD_W{1'b0}};
      wd_reg   <= {DQ_W{1'b0}};
      cke_reg <= `CTRL_CKE_RST;
    end else if (aw_reg && w_reg) begin
      if (awaddr_reg == `OFS_ADDR) addr_reg <= wdata_reg[AD_W-1:0];
      if (awaddr_reg == `OFS_WDATA) wd_reg <= wdata_reg[DQ_W-1:0];
      if (awaddr_reg == `OFS_CTRL) cke_reg <= wdata_reg[`CTRL_CKE_LSB];
    end
  end

  // pin drive: one command cycle per command write, nop otherwise
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'hF;
      pins.bank        <= 2'h0;
      pins.addr        <= {AD_W{1'b0}};
      pins.byte_mask   <= {NB{1'b1}};
      pins.dq_ctl_oe_n <= 1'b1;
      pins.dq_ctl_o    <= {DQ_W{1'b0}};
      pins.cke         <= 1'b1;
    end else begin
      pins.cke <= cke_reg;
      pins.cs_n <= !issue;
      {pins.ras_n, pins.cas_n, pins.we_n} <= issue ?
        wdata_reg[`CMD_OP_LSB +: 3] : 3'h7;
      if (issue) begin
        pins.bank <= wdata_reg[`CMD_BANK_LSB +: 2];
        pins.addr <= addr_reg;
        pins.addr[`AUTO_CLOSE_BIT] <= wdata_reg[`CMD_AUTO_LSB];
        pins.byte_mask <= wdata_reg[`CMD_MASK_LSB +: NB];
      end
      pins.dq_ctl_oe_n <= !(issue_wr || wr_left_reg != 3'h0);
      pins.dq_ctl_o <= wd_reg;
    end
  end

  // read capture: pins cross through two flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dq_s1_reg <= {DQ_W{1'b0}};
      dq_s2_reg <= {DQ_W{1'b0}};
      cap_reg   <= '0;
      rd_reg    <= {DQ_W{1'b0}};
    end else begin
      dq_s1_reg <= pins.dq_i;
      dq_s2_reg <= dq_s1_reg;
      cap_reg   <= {cap_reg[`CAS_LATENCY+1:0], issue_rd};
      // beat 0: read latency, plus the pin flop and both sync flops
      if (cap_reg[`CAS_LATENCY+2]) rd_reg <= dq_s2_reg;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0; s_axi_rdata <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      unique case (s_axi_araddr)
        `OFS_ADDR:   s_axi_rdata <= 32'(addr_reg);
        `OFS_WDATA:  s_axi_rdata <= 32'(wd_reg);
        `OFS_RDATA:  s_axi_rdata <= 32'(rd_reg);
        `OFS_STATUS: s_axi_rdata <= {31'h0, |cap_reg};
        `OFS_CTRL:   s_axi_rdata <= {31'h0, cke_reg};
        default:     s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_rresp = 2'h0;
  logic unused_strb;
  assign unused_strb = ^s_axi_wstrb;
endmodule
`default_nettype wire

// [sdram_pin_props.sv]
// checker of the pin level relations between controller and memory end
// assumes: instantiated in tb_top beside the sdram_pin_if instance
`timescale 1ns/1ps
`default_nettype none
module sdram_pin_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        cke,
  input wire logic        cs_n,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        we_n,
  input wire logic [3:0]  byte_mask,
  input wire logic [31:0] dq_ctl_o,
  input wire logic        dq_ctl_oe_n,
  input wire logic [3:0]  dq_mem_oe_n
);
  // ****************************************
  // command decode
  // ****************************************
  logic is_cmd;
  logic is_rd;
  logic is_wr;
  assign is_cmd = !cs_n && ({ras_n, cas_n, we_n} != 3'h7);
  assign is_rd  = !cs_n && ({ras_n, cas_n, we_n} == 3'h5);
  assign is_wr  = !cs_n && ({ras_n, cas_n, we_n} == 3'h4);

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ****************************************
  // assertions
  // ****************************************
  cmd_one_cycle_a: assert property (is_cmd |=> !is_cmd)
    else $error("command strobes held past one cycle");
  reset_pins_a: assert property ($rose(aresetn) |->
    !is_cmd && cke && byte_mask == 4'hF)
    else $error("pins not idle after reset");
  read_mask_float_a: assert property (is_rd |->
    ##3 (dq_mem_oe_n == $past(byte_mask, 2))[*4])
    else $error("read lane enable does not follow mask two cycles back");
  mem_quiet_a: assert property (!$past(is_rd, 3) && !$past(is_rd, 4)
    && !$past(is_rd, 5) && !$past(is_rd, 6) |-> dq_mem_oe_n == 4'hF)
    else $error("memory drives data outside a read burst");
  no_fight_a: assert property (!dq_ctl_oe_n |-> dq_mem_oe_n == 4'hF)
    else $error("both ends drive the data bus");
  write_drive_a: assert property (is_wr |-> (!dq_ctl_oe_n)[*4])
    else $error("controller not driving all write beats");
  write_hold_a: assert property (is_wr |=> $stable(dq_ctl_o)[*3])
    else $error("write data changed within the burst");
  ctl_quiet_a: assert property (!is_wr && !$past(is_wr)
    && !$past(is_wr, 2) && !$past(is_wr, 3) |-> dq_ctl_oe_n)
    else $error("controller drives data outside a write burst");

  cover property (is_rd ##1 byte_mask != 4'h0);
  cover property (is_wr);
  cover property ($fell(cke));
endmodule
`default_nettype wire

// [tb_top.sv]
// self-checking bench: both ends joined, driven over axi4-lite
// assumes: package, interface and both design ends compiled first
`timescale 1ns/1ps
`default_nettype none
`include "sdram_pin_regs.svh"
module tb_top;
  logic                aclk;
  logic                aresetn;
  logic [11:0]         s_axi_awaddr;
  logic                s_axi_awvalid;
  logic                s_axi_awready;
  logic [31:0]         s_axi_wdata;
  logic                s_axi_wvalid;
  logic                s_axi_wready;
  logic [1:0]          s_axi_bresp;
  logic                s_axi_bvalid;
  logic                s_axi_bready;
  logic [11:0]         s_axi_araddr;
  logic                s_axi_arvalid;
  logic                s_axi_arready;
  logic [31:0]         s_axi_rdata;
  logic [1:0]          s_axi_rresp;
  logic                s_axi_rvalid;
  logic                s_axi_rready;
  sdram_pin_pkg::pwr_t pwr_state;
  logic [12:0]         mode_word;
  logic [7:0]          float_pat = 8'hA5;
  int                  num_errors;
  int                  checks_done;

  sdram_pin_if pins (.aclk(aclk));
  sdram_ctl sdram_ctl_inst (.aclk(aclk), .aresetn(aresetn), .pins(pins.ctl),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
  sdram_mem sdram_mem_inst (.aclk(aclk), .aresetn(aresetn), .pins(pins.mem),
    .pwr_state(pwr_state), .mode_word(mode_word));
  sdram_pin_props props (.aclk(aclk), .aresetn(aresetn), .cke(pins.cke),
    .cs_n(pins.cs_n), .ras_n(pins.ras_n), .cas_n(pins.cas_n),
    .we_n(pins.we_n), .byte_mask(pins.byte_mask), .dq_ctl_o(pins.dq_ctl_o),
    .dq_ctl_oe_n(pins.dq_ctl_oe_n), .dq_mem_oe_n(pins.dq_mem_oe_n));

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // ****************************************
  // shared data bus, a released lane changes every cycle
  // ****************************************
  always @(posedge aclk) float_pat <= float_pat + 8'h35;
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      if (!pins.dq_ctl_oe_n)
        pins.dq_i[b*8 +: 8] = pins.dq_ctl_o[b*8 +: 8];
      else if (!pins.dq_mem_oe_n[b])
        pins.dq_i[b*8 +: 8] = pins.dq_mem_o[b*8 +: 8];
      else
        pins.dq_i[b*8 +: 8] = float_pat ^ 8'(b);
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic timed_out(input int n);
    if (n >= 100) begin
      num_errors++;
      $display("ERROR axi answer expected 1 seen 0");
      stop_test();
    end
  endtask

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 100);
    s_axi_bready <= 1'b0;
    timed_out(n);
    chk("bresp", 32'h0, {30'h0, s_axi_bresp});
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 100);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    timed_out(n);
  endtask

  // one pin command, then room for the burst and read latency
  task automatic issue(input sdram_pin_pkg::cmd_t c, input logic [1:0] bk,
                       input logic [3:0] msk, input logic ac,
                       input logic [12:0] ad);
    axi_wr(`OFS_ADDR, {19'h0, ad});
    axi_wr(`OFS_CMD, {19'h0, ac, msk, 2'h0, bk, 1'b0, c[2:0]});
    repeat (8) @(posedge aclk);
  endtask

  task automatic rd_word(input logic [1:0] bk, input logic [3:0] msk,
                         output logic [31:0] d);
    issue(sdram_pin_pkg::cmd_read, bk, msk, 1'b0, 13'h0000);
    axi_rd(`OFS_STATUS, d);
    chk("read busy", 32'h0, d & 32'h1);
    axi_rd(`OFS_RDATA, d);
  endtask

  task automatic wait_pwr(input sdram_pin_pkg::pwr_t e);
    int n;
    n = 0;
    while (pwr_state !== e && n < 20) begin
      @(posedge aclk);
      n++;
    end
    chk("pwr_state", {29'h0, e}, {29'h0, pwr_state});
    if (n >= 20) stop_test();
  endtask

  // clock enable low until state e shows, then back to running
  task automatic nap(input sdram_pin_pkg::pwr_t e);
    axi_wr(`OFS_CTRL, 32'h0);
    wait_pwr(e);
    axi_wr(`OFS_CTRL, 32'h1);
    wait_pwr(sdram_pin_pkg::pwr_run);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset_vals();
    logic [31:0] d;
    chk("pwr_state", 32'h0, {29'h0, pwr_state});
    axi_rd(`OFS_CTRL, d);
    chk("ctrl cke", 32'h1, d & 32'h1);
    axi_rd(12'h0FC, d);
    chk("unmapped", 32'h0, d);
  endtask

  task automatic t_mode();
    logic [12:0] v [2] = '{13'h0032, 13'h1A5C};
    for (int i = 0; i < 2; i++) begin
      issue(sdram_pin_pkg::cmd_load_mode, 2'h0, 4'h0, 1'b0, v[i]);
      chk("mode_word", {19'h0, v[i]}, {19'h0, mode_word});
    end
  endtask

  task automatic t_write_mask();
    logic [31:0] d;
    logic [31:0] e;
    logic [31:0] nw;
    issue(sdram_pin_pkg::cmd_activate, 2'h1, 4'h0, 1'b0, 13'h0005);
    issue(sdram_pin_pkg::cmd_activate, 2'h2, 4'h0, 1'b0, 13'h0005);
    axi_wr(`OFS_WDATA, 32'hAABBCCDD);
    issue(sdram_pin_pkg::cmd_write, 2'h2, 4'h0, 1'b0, 13'h0000);
    e = 32'h11223344;
    axi_wr(`OFS_WDATA, e);
    issue(sdram_pin_pkg::cmd_write, 2'h1, 4'h0, 1'b0, 13'h0000);
    for (int k = 0; k < 4; k++) begin
      nw = {4{8'h60 + 8'(k)}};
      axi_wr(`OFS_WDATA, nw);
      issue(sdram_pin_pkg::cmd_write, 2'h1, 4'(1 << k), 1'b0, 13'h0000);
      for (int j = 0; j < 4; j++)
        if (j != k) e[j*8 +: 8] = nw[j*8 +: 8];
      rd_word(2'h1, 4'h0, d);
      chk("masked write", e, d);
    end
    rd_word(2'h2, 4'h0, d);
    chk("other bank", 32'hAABBCCDD, d);
    rd_word(2'h1, 4'hA, d);
    chk("masked read", e & 32'h00FF00FF, d & 32'h00FF00FF);
  endtask

  task automatic t_power();
    logic [12:0] m;
    nap(sdram_pin_pkg::pwr_active_down);
    issue(sdram_pin_pkg::cmd_precharge, 2'h1, 4'h0, 1'b0, 13'h0000);
    nap(sdram_pin_pkg::pwr_active_down);
    issue(sdram_pin_pkg::cmd_precharge, 2'h2, 4'h0, 1'b0, 13'h0000);
    axi_wr(`OFS_CTRL, 32'h0);
    wait_pwr(sdram_pin_pkg::pwr_idle_down);
    m = mode_word;
    issue(sdram_pin_pkg::cmd_load_mode, 2'h0, 4'h0, 1'b0, 13'h0777);
    chk("mode while down", {19'h0, m}, {19'h0, mode_word});
    axi_wr(`OFS_CTRL, 32'h1);
    wait_pwr(sdram_pin_pkg::pwr_run);
    issue(sdram_pin_pkg::cmd_activate, 2'h3, 4'h0, 1'b0, 13'h0009);
    issue(sdram_pin_pkg::cmd_write, 2'h3, 4'h0, 1'b1, 13'h0000);
    nap(sdram_pin_pkg::pwr_idle_down);
    issue(sdram_pin_pkg::cmd_activate, 2'h0, 4'h0, 1'b0, 13'h0003);
    issue(sdram_pin_pkg::cmd_precharge, 2'h2, 4'h0, 1'b1, 13'h0400);
    nap(sdram_pin_pkg::pwr_idle_down);
  endtask

  initial begin
    num_errors    = 0;
    checks_done   = 0;
    aresetn       = 1'b0;
    s_axi_awaddr  = 12'h000;
    s_axi_awvalid = 1'b0;
    s_axi_wdata   = 32'h0;
    s_axi_wvalid  = 1'b0;
    s_axi_bready  = 1'b0;
    s_axi_araddr  = 12'h000;
    s_axi_arvalid = 1'b0;
    s_axi_rready  = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_vals();
    t_mode();
    t_write_mask();
    t_power();
    stop_test();
  end
endmodule
`default_nettype wire
